// ==== lcd_pkg.sv ====
// Shared constants, encodings and register map of the LCD command decoder.
`default_nettype none
package lcd_pkg;
  // Register byte addresses on the APB side.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DISP = 8'h04;
  localparam logic [7:0] REG_SUPPLY = 8'h08;
  localparam logic [7:0] REG_PTR = 8'h0C;
  localparam logic [7:0] REG_TEMP = 8'h10;
  // Field positions of the control register.
  localparam int CTRL_SA_LSB = 0;
  localparam logic [1:0] CTRL_SA_RST = 2'h0;
  // Fixed upper five bits of the bus slave address.
  localparam logic [4:0] SLAVE_PREFIX = 5'h0F;
  // Command pages.
  localparam logic [2:0] PAGE_FUNC = 3'h7;
  localparam logic [2:0] PAGE_DISP = 3'h6;
  localparam logic [2:0] PAGE_HV = 3'h5;
  localparam logic [2:0] PAGE_SPEC = 3'h3;
  localparam logic [2:0] PAGE_RST = 3'h0;
  // Pointer limits.
  localparam logic [7:0] COL_LAST = 8'h84;
  localparam logic [3:0] BANK_LAST = 4'h8;
  // Reset values of stored settings.
  localparam logic [1:0] DMODE_RST = 2'h0;
  localparam logic [2:0] BIAS_RST = 3'h0;
  localparam logic [2:0] MUX_RST = 3'h0;
  localparam logic [6:0] VOP_RST = 7'h00;
  localparam logic [1:0] STAGES_RST = 2'h0;
  localparam logic [2:0] TC_RST = 3'h0;
  localparam logic [7:0] TEMP_RST = 8'h00;
  localparam logic PD_RST = 1'b1;
  // Pump multiplication offset: stage code 0 means times two.
  localparam logic [2:0] PUMP_BASE = 3'h2;
  // Bus bits per byte before the acknowledge slot.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Byte returned for a read with the data selector set.
  localparam logic [7:0] NO_READ_BYTE = 8'hFF;

  // Serial link states, Gray coded along the receive path.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_RX = 3'h2,
    ST_RACK = 3'h6,
    ST_TX = 3'h7,
    ST_TACK = 3'h5
  } lcd_state_t;

  // Resolved supply mode.
  typedef enum logic [2:0] {
    SUP_PDOWN = 3'h0,
    SUP_ANAOFF = 3'h1,
    SUP_PUMP = 3'h3,
    SUP_DIRECT = 3'h2,
    SUP_EXTERN = 3'h6
  } lcd_supply_t;
endpackage : lcd_pkg
`default_nettype wire

// ==== lcd_cmd_decoder.sv ====
// Serial-bus command decoder for a paged LCD matrix driver instruction set.
`default_nettype none
module lcd_cmd_decoder
  import lcd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic temp_done,
  input wire logic [7:0] temp_value,
  output logic measure_start,
  output logic disp_blank,
  output logic disp_normal,
  output logic disp_all_on,
  output logic disp_inverse,
  output logic vert_flip,
  output logic top_pad_flip,
  output logic bottom_pad_flip,
  output logic [2:0] bias_select,
  output logic [2:0] mux_rate,
  output logic drive_strength,
  output logic [6:0] operating_voltage,
  output logic pump_range,
  output logic [2:0] pump_factor,
  output logic [2:0] temp_coeff,
  output logic [2:0] supply_mode,
  output logic hv_gen_on,
  output logic analog_off,
  output logic int_osc_on,
  output logic ext_clk_sel,
  output logic outputs_grounded,
  output logic ram_we,
  output logic [7:0] ram_col,
  output logic [3:0] ram_bank,
  output logic [7:0] ram_data
);

  // Synchroniser and edge history for the bus pins.
  logic scl_s1_ff, scl_s2_ff, scl_s3_ff, sda_s1_ff, sda_s2_ff, sda_s3_ff;
  lcd_state_t state_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff;
  logic rw_ff, ctl_expect_ff, cont_ff, dc_ff, oe_ff;
  // Stored settings.
  logic [2:0] page_ff;
  logic [1:0] dmode_ff, sa_ff, stages_ff;
  logic horiz_flip_ff, vert_flip_ff, drive_ff, top_ff, bot_ff;
  logic [2:0] bias_ff, mux_ff, tc_ff;
  logic [6:0] vop_ff;
  logic range_ff, pump_en_ff, meas_ff, dof_ff, dm_ff, ec_ff, pd_ff, vaddr_ff;
  logic [7:0] col_ptr_ff, temp_ff;
  logic [3:0] bank_ff;
  // Registered outputs.
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff, we_ff;
  logic [7:0] wcol_ff, wdata_ff;
  logic [3:0] wbank_ff;
  logic [3:0] dmode_dec_ff;
  logic [2:0] supply_ff, factor_ff;
  logic hv_on_ff, ana_off_ff, osc_on_ff, grounded_ff;

  // Bus pin events, taken from the settled synchroniser stages only.
  wire scl_rise = scl_s2_ff & ~scl_s3_ff;
  wire scl_fall = ~scl_s2_ff & scl_s3_ff;
  wire start_det = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
  wire stop_det = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;
  wire byte_full = (cnt_ff == BITS_PER_BYTE);
  wire addr_match = (sh_ff[7:1] == {SLAVE_PREFIX, sa_ff});
  wire rx_done = (state_ff == ST_RX) & scl_fall & byte_full;
  wire ctl_ev = rx_done & ctl_expect_ff;
  wire ram_ev = rx_done & ~ctl_expect_ff & dc_ff;
  wire cmd_ev = rx_done & ~ctl_expect_ff & ~dc_ff;
  wire [7:0] tx_byte = dc_ff ? NO_READ_BYTE : temp_ff;

  // Command byte field matches.
  wire [7:0] b = sh_ff;
  wire is_nop = (b == 8'h00);
  wire is_dflt = (b == 8'h01);
  wire on_func = cmd_ev & (page_ff == PAGE_FUNC) & ~is_nop & ~is_dflt;
  wire on_disp = cmd_ev & (page_ff == PAGE_DISP) & ~is_nop & ~is_dflt;
  wire on_hv = cmd_ev & (page_ff == PAGE_HV) & ~is_nop & ~is_dflt;
  wire on_spec = cmd_ev & (page_ff == PAGE_SPEC) & ~is_nop & ~is_dflt;
  wire pg_ok = (b[2:0] == PAGE_DISP) | (b[2:0] == PAGE_HV) | (b[2:0] == PAGE_SPEC);
  wire f_page = on_func & (b[7:3] == 5'h01) & pg_ok;
  wire f_fset = on_func & (b[7:3] == 5'h02) & ~b[0];
  wire f_rpage = on_func & (b[7:3] == 5'h04) & (b[1:0] == 2'h0);
  wire f_ybank = on_func & (b[7:4] == 4'h4) & (b[3:0] <= BANK_LAST);
  wire f_xcol = on_func & b[7];
  wire d_mode = on_disp & (b[7:2] == 6'h01);
  wire d_flip = on_disp & (b[7:3] == 5'h01) & ~b[0];
  wire d_bias = on_disp & (b[7:3] == 5'h02);
  wire d_size = on_disp & (b[7:3] == 5'h04) & (b[1:0] == 2'h0);
  wire d_mux = on_disp & (b[7:3] == 5'h10);
  wire h_ctrl = on_hv & (b[7:2] == 6'h01);
  wire h_stg = on_hv & (b[7:2] == 6'h02);
  wire h_tc = on_hv & (b[7:3] == 5'h02);
  wire h_sm = on_hv & (b[7:1] == 7'h10);
  wire h_vop = on_hv & b[7];
  wire s_state = on_spec & (b[7:2] == 6'h01);
  wire s_osc = on_spec & (b[7:2] == 6'h02) & ~b[0];
  wire s_cog = on_spec & (b[7:5] == 3'h2) & (b[2:0] == 3'h0);

  // RAM write placement and pointer advance; flip acts only on placement.
  wire [7:0] wr_col = horiz_flip_ff ? (COL_LAST - col_ptr_ff) : col_ptr_ff;
  wire col_end = (col_ptr_ff >= COL_LAST);
  wire bank_end = (bank_ff >= BANK_LAST);
  wire [7:0] col_inc = col_end ? 8'h00 : (col_ptr_ff + 8'h01);
  wire [3:0] bank_inc = bank_end ? 4'h0 : (bank_ff + 4'h1);
  wire [7:0] nxt_col = (vaddr_ff & ~bank_end) ? col_ptr_ff : col_inc;
  wire [3:0] nxt_bank = (vaddr_ff | col_end) ? bank_inc : bank_ff;

  // Supply mode by priority.
  wire [2:0] nxt_supply = pd_ff ? SUP_PDOWN :
                          dof_ff ? SUP_ANAOFF :
                          pump_en_ff ? SUP_PUMP :
                          dm_ff ? SUP_DIRECT : SUP_EXTERN;

  // APB decode; the slave answers in the first access cycle.
  wire apb_setup = psel & ~penable;
  wire apb_done = psel & penable & pready_ff;
  wire hit_ctrl = (paddr == REG_CTRL);
  wire hit_any = hit_ctrl | (paddr == REG_DISP) | (paddr == REG_SUPPLY) |
                 (paddr == REG_PTR) | (paddr == REG_TEMP);
  wire [31:0] rd_disp = {16'h0, mux_ff, bias_ff, drive_ff, horiz_flip_ff,
                         vert_flip_ff, top_ff, bot_ff, page_ff, dmode_ff};
  wire [31:0] rd_supply = {5'h0, supply_ff, vop_ff, range_ff, pump_en_ff,
                           stages_ff, tc_ff, meas_ff, dof_ff, dm_ff, ec_ff, pd_ff, 5'h0};
  wire [31:0] rd_ptr = {19'h0, vaddr_ff, bank_ff, col_ptr_ff};
  wire [31:0] rd_mux = hit_ctrl ? {30'h0, sa_ff} :
                       (paddr == REG_DISP) ? rd_disp :
                       (paddr == REG_SUPPLY) ? rd_supply :
                       (paddr == REG_PTR) ? rd_ptr :
                       (paddr == REG_TEMP) ? {24'h0, temp_ff} : 32'h0;

  // Two-flop synchronisers plus one history stage for edge finding.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      {scl_s1_ff, scl_s2_ff, scl_s3_ff} <= 3'h7;
      {sda_s1_ff, sda_s2_ff, sda_s3_ff} <= 3'h7;
    end
    else
    begin
      {scl_s1_ff, scl_s2_ff, scl_s3_ff} <= {scl_in, scl_s1_ff, scl_s2_ff};
      {sda_s1_ff, sda_s2_ff, sda_s3_ff} <= {sda_in, sda_s1_ff, sda_s2_ff};
    end
  end

  // Bus slave sequencer; SDA only changes while SCL is low.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      {rw_ff, ctl_expect_ff, cont_ff, dc_ff, oe_ff} <= 5'h08;
    end
    else if (start_det)
    begin
      state_ff <= ST_ADDR;
      cnt_ff <= 4'h0;
      oe_ff <= 1'b0;
      ctl_expect_ff <= 1'b1;
    end
    else if (stop_det)
    begin
      state_ff <= ST_IDLE;
      oe_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_ADDR, ST_RX:
        begin
          if (scl_rise & ~byte_full)
          begin
            sh_ff <= {sh_ff[6:0], sda_s2_ff};
            cnt_ff <= cnt_ff + 4'h1;
          end
          else if (scl_fall & byte_full)
          begin
            oe_ff <= (state_ff == ST_RX) | addr_match;
            if (state_ff == ST_RX)
            begin
              state_ff <= ST_RACK;
              // A control byte sets the mode; data re-arms it only on continuation.
              ctl_expect_ff <= ctl_expect_ff ? 1'b0 : cont_ff;
              if (ctl_expect_ff)
              begin
                cont_ff <= sh_ff[7];
                dc_ff <= sh_ff[6];
              end
            end
            else if (addr_match)
            begin
              state_ff <= ST_AACK;
              rw_ff <= sh_ff[0];
            end
            else
              state_ff <= ST_IDLE;
          end
        end
        ST_AACK:
        begin
          if (scl_fall)
          begin
            cnt_ff <= 4'h0;
            state_ff <= rw_ff ? ST_TX : ST_RX;
            oe_ff <= rw_ff & ~tx_byte[7];
            sh_ff <= {tx_byte[6:0], 1'b0};
          end
        end
        ST_RACK:
        begin
          if (scl_fall)
          begin
            oe_ff <= 1'b0;
            cnt_ff <= 4'h0;
            state_ff <= ST_RX;
          end
        end
        ST_TX:
        begin
          if (scl_rise)
            cnt_ff <= cnt_ff + 4'h1;
          else if (scl_fall & byte_full)
          begin
            oe_ff <= 1'b0;
            state_ff <= ST_TACK;
          end
          else if (scl_fall)
          begin
            oe_ff <= ~sh_ff[7];
            sh_ff <= {sh_ff[6:0], 1'b0};
          end
        end
        ST_TACK:
        begin
          // A high acknowledge ends the read and SDA stays released.
          if (scl_rise & sda_s2_ff)
            state_ff <= ST_IDLE;
          else if (scl_fall)
          begin
            cnt_ff <= 4'h0;
            state_ff <= ST_TX;
            oe_ff <= ~tx_byte[7];
            sh_ff <= {tx_byte[6:0], 1'b0};
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Page, addressing and function settings; writes are taken in power-down too.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      page_ff <= PAGE_RST;
      {pd_ff, vaddr_ff} <= {PD_RST, 1'b0};
      col_ptr_ff <= 8'h00;
      bank_ff <= 4'h0;
    end
    else
    begin
      if (cmd_ev & is_dflt)
        page_ff <= PAGE_FUNC;
      else if (f_page)
        page_ff <= b[2:0];
      if (f_fset)
        {pd_ff, vaddr_ff} <= b[2:1];
      if (ram_ev)
      begin
        col_ptr_ff <= nxt_col;
        bank_ff <= nxt_bank;
      end
      else
      begin
        if (f_rpage)
          col_ptr_ff[7] <= b[2];
        if (f_xcol)
          col_ptr_ff[6:0] <= b[6:0];
        if (f_ybank)
          bank_ff <= b[3:0];
      end
    end
  end

  // Display, generator and special feature settings.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      dmode_ff <= DMODE_RST;
      {horiz_flip_ff, vert_flip_ff, drive_ff, top_ff, bot_ff} <= 5'h00;
      bias_ff <= BIAS_RST;
      mux_ff <= MUX_RST;
      vop_ff <= VOP_RST;
      stages_ff <= STAGES_RST;
      tc_ff <= TC_RST;
      {range_ff, pump_en_ff, meas_ff, dof_ff, dm_ff, ec_ff} <= 6'h00;
      temp_ff <= TEMP_RST;
    end
    else
    begin
      if (d_mode)
        dmode_ff <= b[1:0];
      if (d_flip)
        {horiz_flip_ff, vert_flip_ff} <= b[2:1];
      if (d_bias)
        bias_ff <= b[2:0];
      if (d_size)
        drive_ff <= b[2];
      if (d_mux)
        mux_ff <= b[2:0];
      if (h_ctrl)
        {range_ff, pump_en_ff} <= b[1:0];
      if (h_stg)
        stages_ff <= b[1:0];
      if (h_tc)
        tc_ff <= b[2:0];
      if (h_vop)
        vop_ff <= b[6:0];
      // A start request in the completion cycle wins so it is never lost.
      if (h_sm & b[0])
        meas_ff <= 1'b1;
      else if (temp_done)
        meas_ff <= 1'b0;
      if (temp_done)
        temp_ff <= temp_value;
      if (s_state)
        {dof_ff, dm_ff} <= b[1:0];
      if (s_osc)
        ec_ff <= b[1];
      if (s_cog)
        {top_ff, bot_ff} <= b[4:3];
    end
  end

  // Derived analog controls, one cycle behind the stored settings.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      dmode_dec_ff <= 4'h1;
      supply_ff <= SUP_PDOWN;
      factor_ff <= PUMP_BASE;
      {hv_on_ff, ana_off_ff, osc_on_ff, grounded_ff} <= 4'h5;
    end
    else
    begin
      dmode_dec_ff <= 4'h1 << dmode_ff;
      supply_ff <= nxt_supply;
      factor_ff <= {1'b0, stages_ff} + PUMP_BASE;
      hv_on_ff <= (nxt_supply == SUP_PUMP);
      ana_off_ff <= (nxt_supply == SUP_ANAOFF) | (nxt_supply == SUP_PDOWN);
      // Stopping the oscillator while the display runs is the host's hazard.
      osc_on_ff <= ~ec_ff & ~pd_ff;
      grounded_ff <= pd_ff;
    end
  end

  // APB slave: ready for one cycle in the access phase, error on unmapped.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      prdata_ff <= 32'h0;
      {pready_ff, pslverr_ff} <= 2'h0;
      sa_ff <= CTRL_SA_RST;
      {we_ff, wcol_ff, wbank_ff, wdata_ff} <= 21'h0;
    end
    else
    begin
      pready_ff <= apb_setup;
      pslverr_ff <= apb_setup & ~hit_any;
      prdata_ff <= (apb_setup & ~pwrite) ? rd_mux : 32'h0;
      if (apb_done & pwrite & hit_ctrl)
        sa_ff <= pwdata[CTRL_SA_LSB +: 2];
      we_ff <= ram_ev;
      if (ram_ev)
        {wcol_ff, wbank_ff, wdata_ff} <= {wr_col, bank_ff, sh_ff};
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign sda_out = 1'b0;
  assign sda_oe = oe_ff;
  assign measure_start = meas_ff;
  // The code is {D,E}: 01 lights all segments and 10 is normal mode.
  assign {disp_inverse, disp_normal, disp_all_on, disp_blank} = dmode_dec_ff;
  assign vert_flip = vert_flip_ff;
  assign top_pad_flip = top_ff;
  assign bottom_pad_flip = bot_ff;
  assign bias_select = bias_ff;
  assign mux_rate = mux_ff;
  assign drive_strength = drive_ff;
  assign operating_voltage = vop_ff;
  assign pump_range = range_ff;
  assign pump_factor = factor_ff;
  assign temp_coeff = tc_ff;
  assign supply_mode = supply_ff;
  assign hv_gen_on = hv_on_ff;
  assign analog_off = ana_off_ff;
  assign int_osc_on = osc_on_ff;
  assign ext_clk_sel = ec_ff;
  assign outputs_grounded = grounded_ff;
  assign ram_we = we_ff;
  assign ram_col = wcol_ff;
  assign ram_bank = wbank_ff;
  assign ram_data = wdata_ff;

endmodule : lcd_cmd_decoder
`default_nettype wire

// ==== lcd_cmd_decoder_chk.sv ====
// Port-level checks of the LCD command decoder, bound to its top module.
`default_nettype none
module lcd_cmd_decoder_chk
  import lcd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic temp_done,
  input wire logic measure_start,
  input wire logic disp_blank,
  input wire logic disp_normal,
  input wire logic disp_all_on,
  input wire logic disp_inverse,
  input wire logic [2:0] pump_factor,
  input wire logic [2:0] supply_mode,
  input wire logic hv_gen_on,
  input wire logic analog_off,
  input wire logic int_osc_on,
  input wire logic ext_clk_sel,
  input wire logic outputs_grounded,
  input wire logic ram_we,
  input wire logic [7:0] ram_col,
  input wire logic [3:0] ram_bank
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Derived outputs lag stored bits by a cycle, so some checks wait for a settled cause.
  AST_DISP_ONEHOT: assert property
    ($onehot({disp_blank, disp_normal, disp_all_on, disp_inverse}))
    else $error("Display mode outputs are not one-hot.");
  AST_PUMP_FACTOR: assert property (pump_factor >= PUMP_BASE && pump_factor <= 3'h5)
    else $error("Pump factor outside two to five.");
  AST_HV_PUMP: assert property
    (hv_gen_on |-> supply_mode == SUP_PUMP || $past(supply_mode) == SUP_PUMP)
    else $error("Generator on outside pump supply mode.");
  AST_PD_OSC: assert property (outputs_grounded [*2] |-> !int_osc_on)
    else $error("Oscillator running in power-down.");
  AST_EXT_OSC: assert property (ext_clk_sel [*2] |-> !int_osc_on)
    else $error("Oscillator running with external clock.");
  AST_PD_SUPPLY: assert property (outputs_grounded [*3] |-> supply_mode == SUP_PDOWN)
    else $error("Power-down does not win supply priority.");
  AST_ANA_OFF: assert property ((supply_mode == SUP_ANAOFF) [*2] |-> analog_off)
    else $error("Analog left on in display-off mode.");
  AST_MEAS_CLR: assert property (measure_start && temp_done |=> !measure_start)
    else $error("Measure start not cleared on completion.");
  AST_RAM_RANGE: assert property (ram_we |-> ram_bank <= BANK_LAST && ram_col <= COL_LAST)
    else $error("RAM write outside the array.");
  AST_WE_PULSE: assert property (ram_we |=> !ram_we)
    else $error("RAM write strobe longer than one cycle.");
  AST_ZERO_WAIT: assert property (psel && penable |-> pready)
    else $error("Bus access cycle without ready.");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("Slave error without ready.");
  COV_INV: cover property ($rose(disp_inverse));
  COV_WE: cover property (ram_we);
  COV_ERR: cover property (pslverr);
endmodule : lcd_cmd_decoder_chk

bind lcd_cmd_decoder lcd_cmd_decoder_chk chk (.sys_clk, .nrst, .psel, .penable, .pready,
  .pslverr, .temp_done, .measure_start, .disp_blank, .disp_normal, .disp_all_on, .disp_inverse,
  .pump_factor, .supply_mode, .hv_gen_on, .analog_off, .int_osc_on, .ext_clk_sel,
  .outputs_grounded, .ram_we, .ram_col, .ram_bank);
`default_nettype wire

// ==== lcd_i2c_master.sv ====
// Behavioural serial bus master that drives the decoder's two-wire link.
`default_nettype none
module lcd_i2c_master
(
  output var logic scl,
  output var logic sda_drv,
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 10ps;
  localparam realtime QTR = 31.25;

  // The clock stands high between frames and the data line is released.
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // One bit slot; data changes only while the clock is low.
  task automatic bit_io(input logic b, output logic s);
    sda_drv = b;
    #QTR scl = 1'b1;
    #QTR s = sda_in;
    #QTR scl = 1'b0;
    #QTR;
  endtask : bit_io

  task automatic start();
    sda_drv = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_drv = 1'b0;
    #QTR scl = 1'b0;
    #QTR;
  endtask : start

  task automatic stop();
    sda_drv = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_drv = 1'b1;
    #QTR;
  endtask : stop

  // Sends a byte MSB first and returns the line level in the acknowledge slot.
  task automatic wr(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, ack);
  endtask : wr

  // Reads a byte; the final byte of a read is answered with a not-acknowledge.
  task automatic rd(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask : rd
endmodule : lcd_i2c_master
`default_nettype wire

// ==== lcd_driver_command_decoder_test.sv ====
// Self-checking bench for the LCD command decoder.
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h expected %h", $time, a, b); end end
module lcd_driver_command_decoder_test
  import lcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 10ps;
  logic sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, temp_value = 8'h00, sa = 8'h78, rb;
  logic [31:0] pwdata = 32'h0, prdata, r, k;
  logic temp_done = 1'b0, a, e, scl_in, sda_drv;
  logic pready, pslverr, sda_oe, measure_start, disp_blank, disp_normal, disp_all_on;
  logic disp_inverse, vert_flip, top_pad_flip, bottom_pad_flip, drive_strength, pump_range;
  logic hv_gen_on, analog_off, int_osc_on, ext_clk_sel, outputs_grounded, ram_we;
  logic [2:0] bias_select, mux_rate, pump_factor, temp_coeff, supply_mode;
  logic [6:0] operating_voltage;
  logic [7:0] ram_col, ram_data;
  logic [3:0] ram_bank;
  logic [3:0] expm [4] = '{4'h8, 4'h2, 4'h4, 4'h1};
  logic [19:0] wq [$];
  wire sda_in;
  int err_count = 0, n_compared = 0;

  // The data line has a pull-up; the decoder only pulls it low.
  assign sda_in = sda_drv & ~sda_oe;
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (ram_we === 1'b1)
      wq.push_back({ram_bank, ram_col, ram_data});

  lcd_cmd_decoder uut (.*, .sda_out());
  lcd_i2c_master m (.scl(scl_in), .sda_drv(sda_drv), .sda_in(sda_in));

  task automatic close_out();
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Control byte first, then every byte must be acknowledged.
  task automatic xfer(input logic [7:0] q [$]);
    logic ack;
    m.start();
    m.wr(sa, ack);
    `CHK(ack, 1'b0)
    foreach (q[i])
    begin
      m.wr(q[i], ack);
      `CHK(ack, 1'b0)
    end
    m.stop();
    repeat (8) @(posedge sys_clk);
  endtask : xfer

  initial
  begin
    #400us;
    err_count++;
    close_out();
  end

  initial
  begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK(outputs_grounded, 1'b1)
    `CHK(int_osc_on, 1'b0)
    `CHK(supply_mode, SUP_PDOWN)
    `CHK(pump_factor, PUMP_BASE)
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b0, REG_CTRL, 32'h0);
    `CHK(r, 32'h1)
    apb(1'b0, 8'h14, 32'h0);
    `CHK(e, 1'b1)
    // The old slave address is foreign now and must be ignored.
    m.start();
    m.wr(8'h78, a);
    `CHK(a, 1'b1)
    m.stop();
    sa = {SLAVE_PREFIX, 2'b01, 1'b0};
    xfer({8'h00, 8'h01, 8'h12, 8'h0E, 8'h0A, 8'h15, 8'h24, 8'h83});
    `CHK(int_osc_on, 1'b1)
    `CHK(vert_flip, 1'b1)
    `CHK({bias_select, mux_rate}, 6'h2B)
    `CHK(drive_strength, 1'b1)
    apb(1'b0, REG_PTR, 32'h0);
    `CHK(r[12], 1'b1)
    for (int i = 0; i < 4; i++)
    begin
      xfer({8'h00, 8'h04 + 8'(i)});
      `CHK({disp_blank, disp_normal, disp_all_on, disp_inverse}, expm[i])
    end
    apb(1'b0, REG_DISP, 32'h0);
    k = r;
    xfer({8'h00, 8'h40, 8'hF0, 8'h00});
    apb(1'b0, REG_DISP, 32'h0);
    `CHK(r, k)
    xfer({8'h00, 8'h01, 8'h0D, 8'h07, 8'h0B, 8'h15, 8'hD5, 8'h21});
    `CHK({pump_range, pump_factor, temp_coeff}, 7'h6D)
    `CHK(operating_voltage, 7'h55)
    `CHK(supply_mode, SUP_PUMP)
    `CHK({hv_gen_on, measure_start}, 2'b11)
    temp_value <= 8'h5A;
    temp_done <= 1'b1;
    @(posedge sys_clk);
    temp_done <= 1'b0;
    @(posedge sys_clk);
    `CHK(measure_start, 1'b0)
    // A leading zero bit exposes a transmitter that keeps driving after the refusal.
    m.start();
    m.wr(sa | 8'h01, a);
    `CHK(a, 1'b0)
    m.rd(1'b0, rb);
    `CHK(rb, 8'h5A)
    m.rd(1'b1, rb);
    `CHK(sda_oe, 1'b0)
    m.stop();
    xfer({8'h00, 8'h06, 8'h01, 8'h0B, 8'h05});
    `CHK({hv_gen_on, supply_mode}, {1'b0, SUP_DIRECT})
    xfer({8'h00, 8'h07});
    `CHK({analog_off, supply_mode}, {1'b1, SUP_ANAOFF})
    // The external pad clock is assumed to keep running while the display is on.
    xfer({8'h00, 8'h0A, 8'h50});
    `CHK({ext_clk_sel, int_osc_on}, 2'b10)
    `CHK({top_pad_flip, bottom_pad_flip}, 2'b10)
    xfer({8'h00, 8'h04, 8'h08, 8'h01, 8'h14, 8'h43, 8'h8A});
    `CHK({outputs_grounded, supply_mode}, {1'b1, SUP_PDOWN})
    xfer({8'h40, 8'h3C, 8'h5A});
    `CHK(wq[0], {4'h3, 8'h0A, 8'h3C})
    `CHK(wq[1], {4'h3, 8'h0B, 8'h5A})
    xfer({8'h00, 8'h01, 8'h0E, 8'h0C, 8'h01, 8'h8A});
    `CHK(vert_flip, 1'b0)
    wq.delete();
    xfer({8'h80, 8'h00, 8'hC0, 8'h99});
    `CHK(wq[0], {4'h3, 8'h7A, 8'h99})
    close_out();
  end
endmodule : lcd_driver_command_decoder_test
`default_nettype wire
